//--- hdl/vil_pkg.sv
/*
  Constants for the detector event latch block: register offsets, field
  positions, reset values and guard timing.
  Assumes a 100 MHz core clock and a 6-bit register address from the link.
*/
package vil_pkg;

  localparam int unsigned ADDR_W    = 6;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned SRC_W     = 5;

  // Register offsets
  localparam logic [5:0] OFF_FALL_EN     = 6'h10;
  localparam logic [5:0] OFF_FALL_SET    = 6'h11;
  localparam logic [5:0] OFF_FALL_CLR    = 6'h12;
  localparam logic [5:0] OFF_STATUS      = 6'h13;
  localparam logic [5:0] OFF_LATCH       = 6'h14;

  // Source bit positions
  localparam int unsigned BIT_HOST_DISC  = 0;
  localparam int unsigned BIT_VBUS_VALID = 1;
  localparam int unsigned BIT_SESS_VALID = 2;
  localparam int unsigned BIT_SESS_END   = 3;
  localparam int unsigned BIT_ID_GROUND  = 4;

  // Reset values
  localparam logic [4:0] FALL_EN_RESET   = 5'h1F;
  localparam logic [4:0] LATCH_RESET     = 5'h00;
  localparam logic [4:0] STATUS_RESET    = 5'h00;
  localparam logic [2:0] RESERVED_READ   = 3'h0;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // Id-ground guard time after the pull-up is enabled
  localparam int unsigned CLOCK_KHZ      = 100000;
  localparam int unsigned ID_GUARD_MS    = 50;
  localparam int unsigned ID_GUARD_CYCLES = ID_GUARD_MS * CLOCK_KHZ;

  typedef enum logic [1:0] {
    GUARD_OFF  = 2'b00,
    GUARD_WAIT = 2'b01,
    GUARD_OPEN = 2'b10
  } vil_guard_t;

endpackage : vil_pkg

//--- hdl/vil_id_guard.sv
/*
  Id-ground guard: holds the id-ground detector masked while the id pull-up
  is off and for a fixed number of cycles after it is switched on.
  Assumes idPullup is synchronous to clock.
*/
`timescale 1ns/1ns
module vil_id_guard #(
  parameter int unsigned GUARD_CYCLES = vil_pkg::ID_GUARD_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic idPullup,
  output logic      guardBusy
);

  localparam int unsigned CNT_W = $clog2(GUARD_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(GUARD_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  vil_pkg::vil_guard_t state_q;
  vil_pkg::vil_guard_t state_d;
  logic [CNT_W-1:0]    count_q;
  logic [CNT_W-1:0]    count_d;
  logic                busy_q;
  logic                busy_d;

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    case (state_q)
      vil_pkg::GUARD_OFF: begin
        count_d = CNT_ZERO;
        if (idPullup) begin
          state_d = vil_pkg::GUARD_WAIT;
        end
      end
      vil_pkg::GUARD_WAIT: begin
        if (!idPullup) begin
          state_d = vil_pkg::GUARD_OFF;
          count_d = CNT_ZERO;
        end else if (count_q == CNT_LAST) begin
          state_d = vil_pkg::GUARD_OPEN;
        end else begin
          count_d = count_q + CNT_ONE;
        end
      end
      vil_pkg::GUARD_OPEN: begin
        if (!idPullup) begin
          state_d = vil_pkg::GUARD_OFF;
        end
      end
      default: begin
        state_d = vil_pkg::GUARD_OFF;
        count_d = CNT_ZERO;
      end
    endcase
    busy_d = (state_d != vil_pkg::GUARD_OPEN);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= vil_pkg::GUARD_OFF;
      count_q <= CNT_ZERO;
      busy_q  <= 1'b1;
    end else if (ce) begin
      state_q <= state_d;
      count_q <= count_d;
      busy_q  <= busy_d;
    end
  end

  assign guardBusy = busy_q;

endmodule : vil_id_guard

//--- hdl/vil_event_latch.sv
/*
  Detector status, falling-edge enables and event latch of the transceiver
  register group at offsets 0x10 to 0x14, reached by a simple register port.
  Assumes detector and mode inputs are synchronous to clock; rising-edge
  enables arrive as a level input from the register block that owns them.
*/
// Operation
// - Clear alias: read enables, ones clear bits
// - Status register read-only, live detector values
// - Id-ground status frozen by pull-up and guard
// - Session-valid and A-valid are one signal
// - Host-disconnect host-mode only, zero in low power
// - Host-disconnect resets to zero, then follows attachment
// - Unmasked detector changes set latch bits
// - Latch cleared on read and on entering low power
// - Latch cleared entering serial or carkit mode
// - Same-cycle event goes to read data and eventPulse, not the latch
// - Falling-edge enables, five bits, reset to one
// - Rising-edge enables gate low-to-high events
// - Id-ground events masked by pull-up guard
// - Host mode needs both pull-downs set
`timescale 1ns/1ns
module vil_event_latch #(
  parameter int unsigned ID_GUARD_CYCLES = vil_pkg::ID_GUARD_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [5:0]  regAddr,
  input  wire logic        regWrite,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  output logic             regRdValid,
  input  wire logic        idGroundIn,
  input  wire logic        sessionEndIn,
  input  wire logic        sessionValidIn,
  input  wire logic        vbusValidIn,
  input  wire logic        hostDisconnectIn,
  input  wire logic        idPullup,
  input  wire logic        dpPulldown,
  input  wire logic        dmPulldown,
  input  wire logic        lowPowerMode,
  input  wire logic        serialMode,
  input  wire logic        carkitMode,
  input  wire logic        clockSuspendM,
  input  wire logic [4:0]  riseEnable,
  output logic             aDeviceValid,
  output logic [4:0]       eventPulse,
  output logic             latchPending
);

  // Edge events of one set of sources against their previous values
  function automatic logic [4:0] edgeEvents(
    input logic [4:0] now,
    input logic [4:0] prev,
    input logic [4:0] riseEn,
    input logic [4:0] fallEn
  );
    edgeEvents = (now & ~prev & riseEn) | (~now & prev & fallEn);
  endfunction : edgeEvents

  function automatic logic [7:0] padRead(input logic [4:0] value);
    padRead = {vil_pkg::RESERVED_READ, value};
  endfunction : padRead

  logic       guardBusy;
  logic [4:0] fallEn_q;
  logic [4:0] fallEn_d;
  logic [4:0] status_q;
  logic [4:0] status_d;
  logic [4:0] latch_q;
  logic [4:0] latch_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rdValid_q;
  logic       rdValid_d;
  logic [4:0] event_q;
  logic [4:0] event_d;
  logic       pending_q;
  logic       pending_d;
  logic       lowPower_q;
  logic       serial_q;
  logic       carkit_q;
  logic       modes_d0;
  logic       modes_d1;
  logic       modes_d2;
  logic       hostMode;
  logic       idFrozen;
  logic       latchRead;
  logic       latchWipe;
  logic [4:0] events;
  logic [4:0] eventMask;

  vil_id_guard #(
    .GUARD_CYCLES (ID_GUARD_CYCLES)
  ) u_id_guard (
    .clock     (clock),
    .rst_n     (rst_n),
    .ce        (ce),
    .idPullup  (idPullup),
    .guardBusy (guardBusy)
  );

  // Mode and source state
  always_comb begin
    hostMode = dpPulldown & dmPulldown;
    idFrozen = !idPullup || guardBusy;
    status_d = status_q;
    // Frozen id-ground bit keeps its last value, no glitch from a floating pin
    if (!idFrozen) begin
      status_d[vil_pkg::BIT_ID_GROUND] = idGroundIn;
    end
    status_d[vil_pkg::BIT_SESS_END]   = sessionEndIn;
    status_d[vil_pkg::BIT_SESS_VALID] = sessionValidIn;
    status_d[vil_pkg::BIT_VBUS_VALID] = vbusValidIn;
    // Out of host mode or in low power the bit carries no meaning
    status_d[vil_pkg::BIT_HOST_DISC]  = hostDisconnectIn && hostMode && !lowPowerMode;
    modes_d0 = lowPowerMode;
    modes_d1 = serialMode;
    modes_d2 = carkitMode;
  end

  // Enables, events and latch
  always_comb begin
    latchRead = regRead && (regAddr == vil_pkg::OFF_LATCH);
    // Clock suspend deliberately not consulted on mode entry
    latchWipe = (lowPowerMode && !lowPower_q) || (serialMode && !serial_q)
              || (carkitMode && !carkit_q);
    eventMask = 5'h1F;
    if (idFrozen) begin
      eventMask[vil_pkg::BIT_ID_GROUND] = 1'b0;
    end
    // Reset value of status is zero, so a disconnected host at reset
    // gives a rising event on the first enabled cycle
    events = edgeEvents(status_d, status_q, riseEnable, fallEn_q) & eventMask;
    event_d = events;

    fallEn_d = fallEn_q;
    if (regWrite) begin
      case (regAddr)
        vil_pkg::OFF_FALL_EN:  fallEn_d = regWdata[4:0];
        vil_pkg::OFF_FALL_SET: fallEn_d = fallEn_q | regWdata[4:0];
        vil_pkg::OFF_FALL_CLR: fallEn_d = fallEn_q & ~regWdata[4:0];
        default:               fallEn_d = fallEn_q;
      endcase
    end

    if (latchWipe) begin
      latch_d = vil_pkg::LATCH_RESET;
    end else if (latchRead) begin
      latch_d = vil_pkg::LATCH_RESET;
    end else begin
      latch_d = latch_q | events;
    end
    pending_d = (latch_d != vil_pkg::LATCH_RESET);
  end

  // Register read port
  always_comb begin
    rdValid_d = regRead;
    rdata_d   = vil_pkg::READ_ZERO;
    if (regRead) begin
      case (regAddr)
        vil_pkg::OFF_FALL_EN:  rdata_d = padRead(fallEn_q);
        vil_pkg::OFF_FALL_SET: rdata_d = padRead(fallEn_q);
        vil_pkg::OFF_FALL_CLR: rdata_d = padRead(fallEn_q);
        vil_pkg::OFF_STATUS:   rdata_d = padRead(status_q);
        vil_pkg::OFF_LATCH:    rdata_d = padRead(latch_q | events);
        default:               rdata_d = vil_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_q   <= vil_pkg::STATUS_RESET;
      lowPower_q <= 1'b0;
      serial_q   <= 1'b0;
      carkit_q   <= 1'b0;
    end else if (ce) begin
      status_q   <= status_d;
      lowPower_q <= modes_d0;
      serial_q   <= modes_d1;
      carkit_q   <= modes_d2;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fallEn_q  <= vil_pkg::FALL_EN_RESET;
      latch_q   <= vil_pkg::LATCH_RESET;
      event_q   <= vil_pkg::LATCH_RESET;
      pending_q <= 1'b0;
    end else if (ce) begin
      fallEn_q  <= fallEn_d;
      latch_q   <= latch_d;
      event_q   <= event_d;
      pending_q <= pending_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q   <= vil_pkg::READ_ZERO;
      rdValid_q <= 1'b0;
    end else if (ce) begin
      rdata_q   <= rdata_d;
      rdValid_q <= rdValid_d;
    end
  end

  assign regRdata     = rdata_q;
  assign regRdValid   = rdValid_q;
  assign aDeviceValid = status_q[vil_pkg::BIT_SESS_VALID];
  // Event pulses feed a receive-command builder outside this block
  assign eventPulse   = event_q;
  assign latchPending = pending_q;

  logic unusedSuspend;
  assign unusedSuspend = clockSuspendM;

endmodule : vil_event_latch

//--- verification/vil_event_latch_props.sv
/*
  Checker for the event latch register port and latch behaviour.
  Bound to vil_event_latch; sees only its ports, one clock domain.
*/
`timescale 1ns/1ns
module vil_event_latch_props (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       ce,
  input wire logic [5:0] regAddr,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       regRdValid,
  input wire logic       sessionValidIn,
  input wire logic       idPullup,
  input wire logic       lowPowerMode,
  input wire logic       serialMode,
  input wire logic       carkitMode,
  input wire logic       aDeviceValid,
  input wire logic [4:0] eventPulse,
  input wire logic       latchPending
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic rdLatch;
  logic anyMode;
  assign rdLatch = ce && regRead && regAddr == vil_pkg::OFF_LATCH;
  assign anyMode = lowPowerMode || serialMode || carkitMode;
  property p_rdValid; ce && regRead |=> regRdValid; endproperty
  a_rdValid: assert property (p_rdValid) else $error("read not answered");
  property p_idle; ce && !regRead |=> !regRdValid && regRdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_rsvd; regRdata[7:5] == 3'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("upper read bits set");
  property p_aValid; ce |=> aDeviceValid == $past(sessionValidIn); endproperty
  a_aValid: assert property (p_aValid) else $error("a-valid differs");
  property p_rdClr; rdLatch |=> !latchPending; endproperty
  a_rdClr: assert property (p_rdClr) else $error("latch kept after read");
  property p_lowPwr; ce && $rose(lowPowerMode) |=> !latchPending; endproperty
  a_lowPwr: assert property (p_lowPwr) else $error("latch kept in low power");
  property p_mode; ce && ($rose(serialMode) || $rose(carkitMode)) |=> !latchPending; endproperty
  a_mode: assert property (p_mode) else $error("latch kept on mode entry");
  // Read and wipe win over same-cycle events, so both are excluded
  property p_evLatch;
    (|eventPulse) && !$past(rdLatch) && !$past(anyMode) |-> latchPending;
  endproperty
  a_evLatch: assert property (p_evLatch) else $error("event not latched");
  property p_idMask; !idPullup && !$past(idPullup) |-> !eventPulse[4]; endproperty
  a_idMask: assert property (p_idMask) else $error("id event while masked");
  c_rdEv: cover property (rdLatch ##1 regRdata != 8'h00);
  c_mode: cover property ($rose(serialMode));
  c_idEv: cover property (eventPulse[4]);
endmodule : vil_event_latch_props

bind vil_event_latch vil_event_latch_props chk (
  .clock, .rst_n, .ce, .regAddr, .regRead, .regRdata, .regRdValid,
  .sessionValidIn, .idPullup, .lowPowerMode, .serialMode, .carkitMode,
  .aDeviceValid, .eventPulse, .latchPending
);

//--- verification/vil_link_model.sv
/*
  Link-side model: register reads and writes, one strobe cycle each.
  Assumes calls start just after a falling clock edge.
*/
`timescale 1ns/1ns
module vil_link_model (
  input  wire logic       clock,
  output logic      [5:0] regAddr,
  output logic            regWrite,
  output logic      [7:0] regWdata,
  output logic            regRead,
  input  wire logic [7:0] regRdata,
  input  wire logic       regRdValid,
  output logic            hang
);
  initial begin
    regAddr = 6'h00;
    regWrite = 1'h0;
    regWdata = 8'h00;
    regRead = 1'h0;
    hang = 1'h0;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1'h1;
    @(negedge clock);
    regWrite = 1'h0;
    regWdata = ~d;
    @(negedge clock);
  endtask : wr
  // Latch polled; receive commands could stand in
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    int n;
    regAddr = a;
    regRead = 1'h1;
    @(negedge clock);
    regRead = 1'h0;
    n = 0;
    while (regRdValid !== 1'h1 && n < 4) begin
      @(negedge clock);
      n++;
    end
    hang = (n == 4);
    d = regRdata;
    @(negedge clock);
  endtask : rd
endmodule : vil_link_model

//--- verification/vil_event_latch_tb.sv
/*
  Testbench for vil_event_latch: link model works the register port,
  bench drives detector and mode levels. Guard shortened to 8 cycles.
*/
`timescale 1ns/1ns
module vil_event_latch_tb;
  logic       clock = 1'h0;
  logic       rst_n = 1'h0;
  logic       ce = 1'h1;
  logic       idGroundIn = 1'h0, sessionEndIn = 1'h0, sessionValidIn = 1'h0;
  logic       vbusValidIn = 1'h0, hostDisconnectIn = 1'h1, idPullup = 1'h0;
  logic       dpPulldown = 1'h1, dmPulldown = 1'h1, lowPowerMode = 1'h0;
  logic       serialMode = 1'h0, carkitMode = 1'h0, clockSuspendM = 1'h0;
  logic [4:0] riseEnable = 5'h1F;
  logic [5:0] regAddr;
  logic [7:0] regWdata, regRdata, d;
  logic       regWrite, regRead, regRdValid, aDeviceValid, latchPending, hang;
  logic [4:0] eventPulse;
  int         fails = 0;
  int         num_checks = 0;

  always #5 clock = ~clock;

  vil_link_model link (.clock, .regAddr, .regWrite, .regWdata, .regRead,
    .regRdata, .regRdValid, .hang);
  vil_event_latch #(.ID_GUARD_CYCLES(8)) uut (.clock, .rst_n, .ce, .regAddr,
    .regWrite, .regWdata, .regRead, .regRdata, .regRdValid, .idGroundIn,
    .sessionEndIn, .sessionValidIn, .vbusValidIn, .hostDisconnectIn, .idPullup,
    .dpPulldown, .dmPulldown, .lowPowerMode, .serialMode, .carkitMode,
    .clockSuspendM, .riseEnable, .aDeviceValid, .eventPulse, .latchPending);

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rc(input logic [5:0] a, input logic [7:0] exp);
    link.rd(a, d);
    chk(d, exp);
  endtask : rc
  task automatic w(input int n);
    repeat (n) @(negedge clock);
  endtask : w
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge hang) begin
    fails++;
    report_and_stop();
  end

  initial begin
    w(2);
    rst_n = 1'h1;
    w(2);
    rc(6'h14, 8'h01);
    rc(6'h14, 8'h00);
    rc(6'h10, 8'h1F);
    link.wr(6'h12, 8'hE1);
    rc(6'h12, 8'h1E);
    link.wr(6'h13, 8'hFF);
    rc(6'h13, 8'h01);
    vbusValidIn = 1'h1;
    sessionValidIn = 1'h1;
    w(1);
    chk({3'h0, eventPulse}, 8'h06);
    w(1);
    chk({7'h00, aDeviceValid}, 8'h01);
    chk({7'h00, latchPending}, 8'h01);
    rc(6'h13, 8'h07);
    rc(6'h14, 8'h06);
    chk({7'h00, latchPending}, 8'h00);
    riseEnable = 5'h17;
    sessionEndIn = 1'h1;
    hostDisconnectIn = 1'h0;
    vbusValidIn = 1'h0;
    w(2);
    rc(6'h14, 8'h02);
    rc(6'h13, 8'h0C);
    riseEnable = 5'h1F;
    hostDisconnectIn = 1'h1;
    w(2);
    lowPowerMode = 1'h1;
    w(2);
    rc(6'h13, 8'h0C);
    rc(6'h14, 8'h00);
    lowPowerMode = 1'h0;
    w(2);
    dmPulldown = 1'h0;
    w(2);
    rc(6'h13, 8'h0C);
    rc(6'h14, 8'h01);
    for (int m = 0; m < 2; m++) begin
      sessionEndIn = ~sessionEndIn;
      clockSuspendM = m[0];
      w(2);
      if (m == 0) serialMode = 1'h1;
      else carkitMode = 1'h1;
      w(2);
      rc(6'h14, 8'h00);
      serialMode = 1'h0;
      carkitMode = 1'h0;
    end
    sessionEndIn = 1'h0;
    rc(6'h14, 8'h08);
    rc(6'h14, 8'h00);
    idGroundIn = 1'h1;
    w(2);
    rc(6'h13, 8'h04);
    rc(6'h14, 8'h00);
    idPullup = 1'h1;
    w(2);
    rc(6'h13, 8'h04);
    w(12);
    rc(6'h13, 8'h14);
    link.rd(6'h14, d);
    idGroundIn = 1'h0;
    w(2);
    rc(6'h14, 8'h10);
    report_and_stop();
  end
endmodule : vil_event_latch_tb
